// File: common/decoder_regs.svh
// register offsets, field positions, reset values and timing for the decoder
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_LAST 8'h08
`define OFF_COUNT 8'h0C
`define CTRL_RUN 0
`define CTRL_EXT 1
`define CTRL_MASK 32'h0000_0003
`define CTRL_RST 32'h0000_0001
`define ST_ERR 6
`define Q_LAST 2'h3
`define F_CAT 15:14
`define F_PFX 15:12
`define F_BOP 13:10
`define F_D 9
`define F_A 8
`define F_F 7:0
`define F_BOP2 13:12
`define F_B 11:9
`define F_LOP 13:10
`define F_LEXT 13:11
`define F_PTR 9:8
`define F_K 7:0
`define F_CSUB 11:10
`define F_S 0
`define F_MM 1:0
`define F_BCND 11
`define F_NL 10:0
`define F_NS 7:0
`define F_LSEL1 11
`define F_HI 7:0
`define F_W2 11:0
`define PFX_CALL 4'hC
`define PFX_BRA 4'hD
`define PFX_LONG 4'hE
`define PFX_SECOND 4'hF
`define BOP_SKIP 4'hC
`define BIT_TEST 2'h3
`define LOP_NONE 4'h0
`define LOP_PTR 4'h1
`define LOP_EXT 3'h7
`define CSUB_CALLRET 2'h1
`define CSUB_TABLE 2'h2
`define CSUB_JUMP 2'h3
`endif

// File: common/decoder_pkg.sv
// types shared by the instruction decoder and its users
package decoder_pkg;
   typedef enum logic [1:0] {CAT_BYTE, CAT_BIT, CAT_LIT, CAT_CTRL} cat_t;
   typedef enum logic [1:0] {S_EXEC, S_OPERAND, S_FLUSH} st_t;
   typedef struct packed {
      logic valid;
      logic is_nop;
      cat_t cat;
      logic [7:0] fadr;
      logic dest_file;
      logic banked;
      logic [2:0] bitn;
      logic [7:0] lit;
      logic [1:0] ptr;
      logic fast;
      logic [1:0] tmode;
      logic [19:0] addr;
      logic two_word;
      logic pc_chg;
      logic is_cond;
      logic ext;
   } dec_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_t;
endpackage

// File: core/instr_decoder.sv
// instruction format decoder with sequencing and apb status registers
//
// Function
// - standard set always decoded; eight extended codes decode only when enabled.
// - four instructions span two words; both fetched before issue.
// - each word splits into opcode bits and operand fields.
// - every word sorts into byte, bit, literal or control category.
// - byte instructions carry file address, destination and access selector.
// - destination zero writes accumulator_register, one writes file register.
// - bit instructions carry file address, bit number and access selector.
// - literal instructions carry constant, optional pointer select, or nothing.
// - control carries program address, call/return mode, table mode or nothing.
// - second word of a two-word instruction has top four bits set.
// - second word reached alone executes as a no-operation.
// - one cycle; taken test or program counter change adds a no-operation cycle.
// - two-word instructions take two instruction cycles; three here when they change the program counter.
// - one instruction cycle lasts four oscillator periods.
// - access selector zero uses fixed region, one uses bank_select_register bank.
// - bit number is three bits, positions zero to seven.
// - fast selector one saves or restores shadow registers, zero leaves them.
// - table mode picks unchanged, post-inc, post-dec or pre-inc table_pointer.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "decoder_regs.svh"
module instr_decoder (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // register bus
   input wire decoder_pkg::apb_req_t apb_req,
   output decoder_pkg::apb_rsp_t apb_rsp,
   // program memory
   input wire logic [15:0] fetch_word,
   output logic fetch_adv,
   // datapath
   input wire logic cond_true,
   output decoder_pkg::dec_t dec,
   output logic issue,
   output logic retire,
   output logic [1:0] ins_cycles,
   output logic q_end
);
   import decoder_pkg::*;

   function automatic dec_t nop_dec();
      dec_t d;
      d = '0;
      d.valid = 1'b1;
      d.is_nop = 1'b1;
      d.cat = CAT_CTRL;
      return d;
   endfunction

   function automatic dec_t decode(input logic [15:0] w, input logic xe);
      dec_t d;
      d = '0;
      d.valid = 1'b1;
      d.fadr = w[`F_F];
      d.banked = w[`F_A];
      case (w[`F_CAT])
         2'h0: begin
            d.cat = CAT_BYTE;
            d.dest_file = w[`F_D];
            d.is_cond = (w[`F_BOP] >= `BOP_SKIP);
         end
         2'h1: begin
            d.cat = CAT_BIT;
            d.bitn = w[`F_B];
            d.is_cond = (w[`F_BOP2] == `BIT_TEST);
         end
         2'h2: begin
            d.cat = CAT_LIT;
            d.fadr = '0;
            d.banked = 1'b0;
            d.lit = (w[`F_LOP] == `LOP_NONE) ? 8'h00 : w[`F_K];
            d.ptr = (w[`F_LOP] == `LOP_PTR) ? w[`F_PTR] : 2'h0;
            d.ext = (w[`F_LEXT] == `LOP_EXT);
            if (d.ext && !xe) begin
               d = nop_dec();
            end
         end
         default: begin
            d.cat = CAT_CTRL;
            d.fadr = '0;
            d.banked = 1'b0;
            case (w[`F_PFX])
               `PFX_CALL: begin
                  if (w[`F_CSUB] == `CSUB_CALLRET) begin
                     d.fast = w[`F_S];
                     d.pc_chg = 1'b1;
                  end else if (w[`F_CSUB] == `CSUB_TABLE) begin
                     d.tmode = w[`F_MM];
                  end else if (w[`F_CSUB] == `CSUB_JUMP) begin
                     d.pc_chg = 1'b1;
                  end
               end
               `PFX_BRA: begin
                  if (w[`F_BCND]) begin
                     d.is_cond = 1'b1;
                     d.addr = {12'h000, w[`F_NS]};
                  end else begin
                     d.pc_chg = 1'b1;
                     d.addr = {9'h000, w[`F_NL]};
                  end
               end
               `PFX_LONG: begin
                  d.two_word = 1'b1;
                  d.addr = {w[`F_HI], 12'h000};
                  d.ptr = w[`F_MM];
                  d.pc_chg = ~w[`F_LSEL1];
               end
               default: d = nop_dec();
            endcase
         end
      endcase
      return d;
   endfunction

   logic [1:0] q_q;
   st_t st_q, st_d;
   dec_t out_q, out_d;
   logic [15:0] first_q, first_d, word_q, word_d;
   logic issue_q, issue_d, retire_q, err_q, err_set, adv;
   logic [1:0] cyc_q;
   logic [15:0] cnt_q;
   logic [31:0] ctrl_q, rdata_q, rdata_d;
   logic rdy_q;
   dec_t dw, dl;

   wire run = ctrl_q[`CTRL_RUN];
   wire ext_en = ctrl_q[`CTRL_EXT];
   wire bnd = ce & run & (q_q == `Q_LAST);
   wire need_flush = out_q.valid & (out_q.pc_chg | (out_q.is_cond & cond_true));
   wire [1:0] base = out_q.two_word ? 2'h2 : 2'h1;
   wire do_retire = bnd & (st_q == S_EXEC) & out_q.valid & ~out_q.is_nop;
   assign dw = decode(fetch_word, ext_en);
   assign dl = decode(first_q, ext_en);

   always_comb begin
      st_d = st_q;
      out_d = out_q;
      issue_d = 1'b0;
      first_d = first_q;
      word_d = word_q;
      err_set = 1'b0;
      adv = 1'b0;
      if (bnd) begin
         case (st_q)
            S_OPERAND: begin
               adv = 1'b1;
               st_d = S_EXEC;
               out_d = dl;
               out_d.addr = {first_q[`F_HI], fetch_word[`F_W2]};
               issue_d = 1'b1;
               word_d = first_q;
               err_set = (fetch_word[`F_PFX] != `PFX_SECOND);
            end
            default: begin
               adv = 1'b1;
               if (st_q == S_EXEC && need_flush) begin
                  st_d = S_FLUSH;
                  out_d = nop_dec();
                  issue_d = 1'b1;
               end else if (dw.two_word) begin
                  st_d = S_OPERAND;
                  first_d = fetch_word;
                  out_d = '0;
               end else begin
                  st_d = S_EXEC;
                  out_d = dw;
                  issue_d = 1'b1;
                  word_d = fetch_word;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_q <= 2'h0;
         st_q <= S_EXEC;
         out_q <= '0;
         first_q <= 16'h0000;
         word_q <= 16'h0000;
         issue_q <= 1'b0;
      end else if (ce) begin
         q_q <= q_q + 2'h1;
         st_q <= st_d;
         out_q <= out_d;
         first_q <= first_d;
         word_q <= word_d;
         issue_q <= issue_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retire_q <= 1'b0;
         cyc_q <= 2'h0;
         cnt_q <= 16'h0000;
      end else if (ce) begin
         retire_q <= do_retire;
         if (do_retire) begin
            cyc_q <= base + {1'b0, need_flush};
         end
         if (issue_d && !out_d.is_nop) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   // apb slave: read data captured in setup, zero-wait access
   wire acc = apb_req.psel & apb_req.penable;
   wire [7:0] pa = apb_req.paddr;
   wire hit_ctrl = (pa == `OFF_CTRL);
   wire hit_stat = (pa == `OFF_STATUS);
   wire mapped = hit_ctrl | hit_stat | (pa == `OFF_LAST) | (pa == `OFF_COUNT);
   wire pready = acc & rdy_q & ce;
   wire wr = pready & apb_req.pwrite;
   wire err_clr = wr & hit_stat & apb_req.pwdata[`ST_ERR];

   always_comb begin
      if (hit_ctrl) begin
         rdata_d = ctrl_q;
      end else if (hit_stat) begin
         rdata_d = {25'h0, err_q, cyc_q, out_q.cat, st_q};
      end else if (pa == `OFF_LAST) begin
         rdata_d = {16'h0000, word_q};
      end else if (pa == `OFF_COUNT) begin
         rdata_d = {16'h0000, cnt_q};
      end else begin
         rdata_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RST;
         err_q <= 1'b0;
         rdy_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         rdy_q <= apb_req.psel & ~pready;
         if (apb_req.psel && !rdy_q) begin
            rdata_q <= rdata_d;
         end
         if (wr && hit_ctrl) begin
            ctrl_q <= apb_req.pwdata & `CTRL_MASK;
         end
         err_q <= err_set | (err_q & ~err_clr);
      end
   end

   assign apb_rsp.pready = pready;
   assign apb_rsp.prdata = rdata_q;
   assign apb_rsp.pslverr = pready & ~mapped;
   assign dec = out_q;
   assign issue = issue_q;
   assign retire = retire_q;
   assign ins_cycles = cyc_q;
   assign q_end = bnd;
   assign fetch_adv = adv;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_quarter; ce && q_q == `Q_LAST |=> q_q == 2'h0; endproperty
   a_quarter: assert property (p_quarter) else $error("quarter wrap");
   property p_cyc; bnd |=> !bnd [*3]; endproperty
   a_cyc: assert property (p_cyc) else $error("cycle shorter than four");
   property p_oper; bnd && st_q == S_EXEC && !need_flush && dw.two_word
      |=> st_q == S_OPERAND && !issue_q; endproperty
   a_oper: assert property (p_oper) else $error("first word dispatched");
   property p_lone; bnd && st_q != S_OPERAND && !(st_q == S_EXEC && need_flush)
      && fetch_word[`F_PFX] == `PFX_SECOND |=> issue_q && dec.is_nop; endproperty
   a_lone: assert property (p_lone) else $error("lone second word not nop");
   property p_dest; issue_q && dec.cat == CAT_BYTE |-> dec.dest_file == word_q[`F_D];
   endproperty
   a_dest: assert property (p_dest) else $error("destination bit lost");
   property p_bitn; issue_q && dec.cat == CAT_BIT |-> dec.bitn == word_q[`F_B]; endproperty
   a_bitn: assert property (p_bitn) else $error("bit number wrong");
   property p_flush; bnd && st_q == S_EXEC && out_q.valid && out_q.pc_chg
      |=> st_q == S_FLUSH && issue_q && dec.is_nop; endproperty
   a_flush: assert property (p_flush) else $error("no flush cycle");
   property p_two; retire_q && $past(out_q.two_word) && !$past(need_flush)
      |-> ins_cycles == 2'h2; endproperty
   a_two: assert property (p_two) else $error("two-word cycles wrong");
   property p_rst; $rose(presetn) |-> st_q == S_EXEC && !out_q.valid; endproperty
   a_rst: assert property (p_rst) else $error("pending state after reset");
   property p_ext; issue_q && dec.ext |-> ext_en; endproperty
   a_ext: assert property (p_ext) else $error("extended code while disabled");
   property p_err; bnd && st_q == S_OPERAND && fetch_word[`F_PFX] != `PFX_SECOND
      |=> err_q; endproperty
   a_err: assert property (p_err) else $error("bad second word not flagged");
   property p_freeze; !ce |=> $stable(out_q) && $stable(q_q) && $stable(st_q); endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while enable low");
   property p_clr; err_clr && !err_set |=> !err_q; endproperty
   a_clr: assert property (p_clr) else $error("error flag not cleared");
endmodule

// File: dv/prog_mem_model.sv
// program memory model that feeds the decoder one word per consumed fetch
`timescale 1ns/100ps
module prog_mem_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // fetch path
   input wire logic fetch_adv,
   output logic [15:0] fetch_word
);
   logic [15:0] mem [64];
   logic [5:0] ptr_q;
   // word stays on the bus until the decoder consumes it
   assign fetch_word = mem[ptr_q];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q <= 6'h00;
      end else if (fetch_adv) begin
         ptr_q <= ptr_q + 6'h01;
      end
   end
endmodule

// File: dv/tb_mcu_instruction_format_decoder.sv
// self-checking bench for the instruction format decoder
`timescale 1ns/100ps
`include "decoder_regs.svh"
module tb_mcu_instruction_format_decoder;
   import decoder_pkg::*;
   logic pclk, presetn, ce, cond_true, fetch_adv, issue, retire, q_end, err;
   logic [15:0] fetch_word;
   logic [1:0] ins_cycles;
   logic [31:0] rd;
   apb_req_t apb_req;
   apb_rsp_t apb_rsp;
   dec_t dec;
   int error_cnt = 0, n_compared = 0, cyc = 0, gap;
   // word, then expected category and key fields
   logic [31:0] rows [11] = '{32'h0012_0012, 32'h03A5_03A5, 32'h4F3C_1F3C, 32'h4001_1001,
      32'h805A_2000, 32'h8677_2277, 32'hC800_3000, 32'hC801_3001, 32'hC802_3002,
      32'hC803_3003, 32'hF123_3FFF};
   logic [15:0] pcw [3] = '{16'hD005, 16'hC400, 16'hC401};

   instr_decoder DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .fetch_word(fetch_word), .fetch_adv(fetch_adv),
      .cond_true(cond_true), .dec(dec), .issue(issue), .retire(retire),
      .ins_cycles(ins_cycles), .q_end(q_end));
   prog_mem_model u_mem (.pclk(pclk), .presetn(presetn), .fetch_adv(fetch_adv),
      .fetch_word(fetch_word));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         $display("wrong value at %0t: run hung", $time);
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic restart();
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic load(input logic [15:0] w0, w1, w2, fill);
      for (int i = 0; i < 64; i++) u_mem.mem[i] = fill;
      u_mem.mem[0] = w0;
      u_mem.mem[1] = w1;
      u_mem.mem[2] = w2;
   endtask

   // gap holds cycles from the call until the next issue
   task automatic next_issue();
      gap = 0;
      do begin
         @(posedge pclk);
         gap++;
      end while (issue !== 1'b1);
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   function automatic logic [31:0] seen_of(dec_t d);
      logic [11:0] k;
      case (d.cat)
         CAT_BYTE: k = {2'h0, d.dest_file, d.banked, d.fadr};
         CAT_BIT: k = {d.bitn, d.banked, d.fadr};
         CAT_LIT: k = {2'h0, d.ptr, d.lit};
         default: k = {10'h000, d.tmode};
      endcase
      return d.is_nop ? 32'h0000_3FFF : {18'h00000, d.cat, k};
   endfunction

   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      cond_true = 1'b0;
      apb_req = '0;
      load(16'h0012, 16'h0012, 16'h0012, 16'h0012);
      for (int i = 0; i < 11; i++) u_mem.mem[i] = rows[i][31:16];
      restart();
      for (int i = 0; i < 11; i++) begin
         next_issue();
         chk(seen_of(dec), {18'h00000, rows[i][13:0]});
         if (i > 0) begin
            chk(gap, 4);
            chk({retire, ins_cycles}, 3'h5);
         end
      end
      $display("format rows done");
      for (int i = 0; i < 3; i++) begin
         load(pcw[i], 16'h4001, 16'h03A5, 16'h0012);
         restart();
         next_issue();
         chk({dec.pc_chg, dec.fast}, {1'b1, i == 2});
         next_issue();
         chk({dec.is_nop, retire, ins_cycles}, 4'hE);
         next_issue();
         chk(dec.fadr, 8'hA5);
      end
      $display("program counter change done");
      for (int ct = 0; ct < 2; ct++) begin
         cond_true <= ct[0];
         load(16'hD803, 16'h0012, 16'h03A5, 16'h0012);
         restart();
         next_issue();
         chk(dec.is_cond, 1'b1);
         next_issue();
         chk({dec.is_nop, ins_cycles}, ct ? 3'h6 : 3'h1);
      end
      $display("conditional test done");
      load(16'hE8AB, 16'hF456, 16'h0012, 16'h0012);
      restart();
      next_issue();
      chk({dec.two_word, dec.addr}, {1'b1, 20'hAB456});
      next_issue();
      chk({retire, ins_cycles, dec.fadr}, {1'b1, 2'h2, 8'h12});
      restart();
      gap = 0;
      do begin
         @(posedge pclk);
         gap++;
      end while (q_end !== 1'b1);
      // let the operand state stand a cycle before asserting reset while in it
      @(posedge pclk);
      u_mem.mem[0] = 16'h0012;
      restart();
      next_issue();
      chk({dec.two_word, dec.fadr}, {1'b0, 8'h12});
      $display("two-word and reset done");
      load(16'hB802, 16'hB802, 16'hB802, 16'hB802);
      restart();
      next_issue();
      chk(dec.is_nop, 1'b1);
      apb(1'b0, `OFF_CTRL, 32'h0);
      chk(rd, `CTRL_RST);
      apb(1'b0, 8'h10, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b1, `OFF_CTRL, 32'h0000_0003);
      apb(1'b0, `OFF_CTRL, 32'h0);
      chk(rd, 32'h0000_0003);
      next_issue();
      next_issue();
      chk({dec.ext, dec.is_nop}, 2'h2);
      $display("register and extended set done");
      ce <= 1'b0;
      repeat (3) @(posedge pclk);
      ce <= 1'b1;
      next_issue();
      chk(gap, 4);
      $display("clock enable done");
      load(16'hE8AB, 16'h0012, 16'h0012, 16'h0012);
      restart();
      next_issue();
      apb(1'b0, `OFF_LAST, 32'h0);
      chk(rd, 32'h0000_E8AB);
      apb(1'b0, `OFF_COUNT, 32'h0);
      chk(rd, 32'h0000_0002);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rd[`ST_ERR], 1'b1);
      apb(1'b1, `OFF_STATUS, 32'h0000_0040);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rd[`ST_ERR], 1'b0);
      $display("bad second word done");
      tally_and_finish();
   end
endmodule
